/* design/uplink_port_media_interface.sv */
//------------------------------------------------------------------------------
// Purpose : Uplink port media interface (MII, GMII, RGMII), PHY-side or MAC-side
// Assumes : Link clocks are slow enough to be sampled by the 40 MHz core clock
// Notes   : Delay bits shift the RGMII ingress sampling edge or the forwarded rx clock pin by one core cycle
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module uplink_port_media_interface (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  // Register port
  input  wire logic                  i_reg_write,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  output logic [7:0]                 o_reg_rdata,
  // Strap, high selects the PHY-side role
  input  wire logic                  i_role_select_strap,
  // Inbound pins; enable doubles as reduced tx control in RGMII
  input  wire logic                  i_uplink_tx_enable_pin,
  input  wire logic                  i_uplink_tx_error_pin,
  input  wire logic [7:0]            i_uplink_tx_data_pins,
  input  wire logic                  i_uplink_gig_tx_clock_pin,
  // Two-way pins
  input  wire logic                  i_uplink_mii_tx_clock_pin,
  output logic                       o_uplink_mii_tx_clock_pin,
  output logic                       o_uplink_mii_tx_clock_pin_oe,
  input  wire logic                  i_uplink_mii_rx_clock_pin,
  output logic                       o_uplink_mii_rx_clock_pin,
  output logic                       o_uplink_mii_rx_clock_pin_oe,
  input  wire logic                  i_uplink_collision_pin,
  output logic                       o_uplink_collision_pin,
  output logic                       o_uplink_collision_pin_oe,
  input  wire logic                  i_uplink_carrier_pin,
  output logic                       o_uplink_carrier_pin,
  output logic                       o_uplink_carrier_pin_oe,
  // Outbound pins; valid doubles as reduced rx control in RGMII
  output logic                       o_uplink_rx_valid_pin,
  output logic                       o_uplink_rx_error_pin,
  output logic [7:0]                 o_uplink_rx_data_pins,
  output logic                       o_uplink_gig_rx_clock_pin,
  // Switch side
  output logic                       o_ing_valid,
  output uplink_pkg::link_word_t     o_ing_word,
  input  wire logic                  i_eg_valid,
  input  wire uplink_pkg::link_word_t i_eg_word,
  output logic                       o_eg_ready,
  // Partner status in MAC-side roles
  output logic                       o_partner_collision,
  output logic                       o_partner_carrier
);
  import uplink_pkg::*;

  typedef struct packed {
    logic [7:0]  cfg;
    pin_sample_t s1;
    pin_sample_t s2;
    logic [1:0]  strap_wait;
    logic        strap_done;
    logic        role_phy;
    logic        ing_prev;
    logic        eg_prev;
    logic        pend_rise;
    logic        pend_fall;
    logic        nib_have;
    logic        nib_err;
    logic [3:0]  nib_low;
    logic        ing_valid;
    link_word_t  ing_word;
    logic [2:0]  div_cnt;
    logic        own_clk;
    logic        grx;
    eg_state_t   eg_state;
    link_word_t  eg_word;
    logic [7:0]  rxd;
    logic        rxv;
    logic        rxe;
    logic        col;
    logic        crs;
    logic [7:0]  rdata;
  } state_t;

  state_t      st;
  state_t      next_st;
  media_mode_t mode;
  logic        is_mii;
  logic        is_gmii;
  logic        is_rgmii;
  logic        gig;
  logic        half;
  logic        ing_clk;
  logic        ing_rise;
  logic        ing_fall;
  logic        take_rise;
  logic        take_fall;
  logic        eg_clk;
  logic        eg_rise;
  logic        eg_fall;
  logic        eg_pop;
  logic        fifo_v;
  link_word_t  fifo_word;
  logic [7:0]  cfg_view;

  //----------------------------------------------------------------------------
  // Mode decode and edge detection
  //----------------------------------------------------------------------------
  assign mode     = media_mode_t'(st.cfg[BIT_MODE_HI:BIT_MODE_LO]);
  assign is_mii   = (mode == MODE_MII);
  assign is_gmii  = (mode == MODE_GMII);
  assign is_rgmii = (mode == MODE_RGMII);
  assign gig      = st.cfg[BIT_SPEED_GIG];
  assign half     = st.cfg[BIT_HALF_DUPLEX];
  // Ingress data is always timed by the clock of the tx-named pins
  assign ing_clk  = is_mii ? (st.role_phy ? st.own_clk : st.s2.txc) : st.s2.gtx;
  assign ing_rise = ing_clk & ~st.ing_prev;
  assign ing_fall = ~ing_clk & st.ing_prev;
  assign take_rise = (is_rgmii && st.cfg[BIT_INGRESS_DLY]) ? st.pend_rise : ing_rise;
  assign take_fall = (is_rgmii && st.cfg[BIT_INGRESS_DLY]) ? st.pend_fall : ing_fall;
  assign eg_clk   = (is_mii && !st.role_phy) ? st.s2.rxc : st.own_clk;
  assign eg_rise  = eg_clk & ~st.eg_prev;
  assign eg_fall  = ~eg_clk & st.eg_prev;
  assign eg_pop   = eg_fall & fifo_v & (is_gmii | ((is_mii | is_rgmii) & (st.eg_state == EG_IDLE)));
  assign cfg_view = {st.cfg[7:BIT_ROLE_RO+1], st.role_phy, st.cfg[BIT_ROLE_RO-1:0]};

  //----------------------------------------------------------------------------
  // Egress buffer
  //----------------------------------------------------------------------------
  link_buffer #(
    .WIDTH ($bits(link_word_t)),
    .DEPTH (EG_DEPTH)
  ) u_eg_buffer (
    .i_clk       (i_clk),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (i_eg_valid),
    .o_in_ready  (o_eg_ready),
    .i_in_data   (i_eg_word),
    .o_out_valid (fifo_v),
    .i_out_ready (eg_pop),
    .o_out_data  (fifo_word)
  );

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.s1 = '{strap: i_role_select_strap, gtx: i_uplink_gig_tx_clock_pin,
                   txc: i_uplink_mii_tx_clock_pin, rxc: i_uplink_mii_rx_clock_pin,
                   en: i_uplink_tx_enable_pin, er: i_uplink_tx_error_pin,
                   col: i_uplink_collision_pin, crs: i_uplink_carrier_pin,
                   data: i_uplink_tx_data_pins};
    next_st.s2 = st.s1;
    // Role stays MAC-side (nothing driven) until the strap has settled
    if (!st.strap_done) begin
      if (st.strap_wait == STRAP_SETTLE) begin
        next_st.role_phy   = st.s2.strap;
        next_st.strap_done = 1'b1;
      end else begin
        next_st.strap_wait = st.strap_wait + 2'h1;
      end
    end
    if (i_reg_write && i_reg_addr == REG_DELAY_ADDR) begin
      next_st.cfg              = i_reg_wdata;
      next_st.cfg[BIT_ROLE_RO] = 1'b0;
    end
    next_st.rdata = (i_reg_addr == REG_DELAY_ADDR) ? cfg_view : 8'h00;
    // Own link clock, also the egress launch clock except in MII MAC-side roles, which launch on the partner rx clock
    if (st.div_cnt == LINK_HALF_CYCLES - 3'h1) begin
      next_st.div_cnt = 3'h0;
      next_st.own_clk = ~st.own_clk;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    next_st.grx       = st.cfg[BIT_EGRESS_DLY] ? st.own_clk : next_st.own_clk;
    next_st.ing_prev  = ing_clk;
    next_st.eg_prev   = eg_clk;
    next_st.pend_rise = ing_rise;
    next_st.pend_fall = ing_fall;
    // Ingress capture
    next_st.ing_valid = 1'b0;
    case (mode)
      MODE_MII: begin
        if (take_rise) begin
          if (!st.s2.en) begin
            next_st.nib_have = 1'b0;
          end else if (!st.nib_have) begin
            next_st.nib_low  = st.s2.data[3:0];
            next_st.nib_err  = st.s2.er;
            next_st.nib_have = 1'b1;
          end else begin
            next_st.ing_word  = '{err: st.nib_err | st.s2.er,
                                  data: {st.s2.data[3:0], st.nib_low}};
            next_st.ing_valid = 1'b1;
            next_st.nib_have  = 1'b0;
          end
        end
      end
      MODE_GMII: begin
        if (take_rise && st.s2.en) begin
          next_st.ing_word  = '{err: st.s2.er, data: st.s2.data};
          next_st.ing_valid = 1'b1;
        end
      end
      MODE_RGMII: begin
        if (take_rise) begin
          next_st.nib_have = st.s2.en;
          next_st.nib_low  = st.s2.data[3:0];
        end else if (take_fall && st.nib_have) begin
          // Falling-edge control is enable xor error
          next_st.ing_word  = '{err: ~st.s2.en, data: {st.s2.data[3:0], st.nib_low}};
          next_st.ing_valid = 1'b1;
          next_st.nib_have  = 1'b0;
        end
      end
      default: begin
        next_st.nib_have = 1'b0;
      end
    endcase
    // Egress launch on the falling edge so the partner samples on the rising one; RGMII launches its high nibble on the rising edge
    case (mode)
      MODE_GMII: begin
        if (eg_fall) begin
          next_st.rxv = fifo_v;
          next_st.rxe = fifo_v & fifo_word.err;
          next_st.rxd = fifo_v ? fifo_word.data : 8'h00;
        end
      end
      MODE_MII: begin
        if (eg_fall) begin
          if (st.eg_state == EG_HIGH) begin
            next_st.rxd      = {4'h0, st.eg_word.data[7:4]};
            next_st.eg_state = EG_IDLE;
          end else if (fifo_v) begin
            next_st.eg_word  = fifo_word;
            next_st.rxd      = {4'h0, fifo_word.data[3:0]};
            next_st.rxv      = 1'b1;
            next_st.rxe      = fifo_word.err;
            next_st.eg_state = EG_HIGH;
          end else begin
            next_st.rxd = 8'h00;
            next_st.rxv = 1'b0;
            next_st.rxe = 1'b0;
          end
        end
      end
      MODE_RGMII: begin
        next_st.rxe = 1'b0;
        if (eg_fall) begin
          next_st.rxv = fifo_v;
          next_st.rxd = fifo_v ? {4'h0, fifo_word.data[3:0]} : 8'h00;
          if (fifo_v) begin
            next_st.eg_word  = fifo_word;
            next_st.eg_state = EG_HIGH;
          end
        end else if (eg_rise && st.eg_state == EG_HIGH) begin
          next_st.rxd      = {4'h0, st.eg_word.data[7:4]};
          next_st.rxv      = ~st.eg_word.err;
          next_st.eg_state = EG_IDLE;
        end
      end
      default: begin
        next_st.rxd      = 8'h00;
        next_st.rxv      = 1'b0;
        next_st.rxe      = 1'b0;
        next_st.eg_state = EG_IDLE;
      end
    endcase
    // Media status driven only in PHY-side roles; RGMII carries none
    next_st.crs = st.role_phy & (is_mii | is_gmii) & (st.s2.en | st.rxv);
    next_st.col = st.role_phy & half & (is_mii | (is_gmii & ~gig)) & st.s2.en & st.rxv;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st     <= '0;
      st.cfg <= REG_DELAY_RESET;
    end else begin
      st <= next_st;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  assign o_reg_rdata                  = st.rdata;
  assign o_uplink_mii_tx_clock_pin    = st.own_clk;
  assign o_uplink_mii_tx_clock_pin_oe = st.role_phy & is_mii;
  assign o_uplink_mii_rx_clock_pin    = st.own_clk;
  assign o_uplink_mii_rx_clock_pin_oe = st.role_phy & is_mii;
  assign o_uplink_collision_pin       = st.col;
  assign o_uplink_collision_pin_oe    = st.role_phy & (is_mii | is_gmii);
  assign o_uplink_carrier_pin         = st.crs;
  assign o_uplink_carrier_pin_oe      = st.role_phy & (is_mii | is_gmii);
  assign o_uplink_rx_valid_pin        = st.rxv;
  assign o_uplink_rx_error_pin        = st.rxe;
  assign o_uplink_rx_data_pins        = st.rxd;
  assign o_uplink_gig_rx_clock_pin    = st.grx & (is_gmii | is_rgmii);
  assign o_ing_valid                  = st.ing_valid;
  assign o_ing_word                   = st.ing_word;
  assign o_partner_collision          = st.s2.col & ~st.role_phy;
  assign o_partner_carrier            = st.s2.crs & ~st.role_phy;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_overlap;
    st.role_phy && half && st.s2.en && st.rxv;
  endsequence
  sequence s_rgmii_launch;
    is_rgmii && eg_fall && fifo_v;
  endsequence

  a_col_mii_overlap:
  assert property (s_overlap and is_mii |=> o_uplink_collision_pin)
    else $error("mii collision missing");
  a_col_gmii_slow:
  assert property (s_overlap and (is_gmii && !gig) |=> o_uplink_collision_pin)
    else $error("gmii 10/100 collision missing");
  a_col_gig_none:
  assert property (is_gmii && gig && $past(is_gmii && gig) |-> !o_uplink_collision_pin)
    else $error("collision at gigabit");
  a_phy_drives_pins:
  assert property (st.role_phy && is_mii |-> o_uplink_mii_tx_clock_pin_oe &&
                   o_uplink_mii_rx_clock_pin_oe && o_uplink_collision_pin_oe)
    else $error("phy role not driving");
  a_mac_no_drive:
  assert property (!st.role_phy |-> !(o_uplink_mii_tx_clock_pin_oe ||
                   o_uplink_mii_rx_clock_pin_oe || o_uplink_carrier_pin_oe))
    else $error("mac role drives partner pin");
  a_strap_once:
  assert property (st.strap_done |=> st.strap_done && $stable(st.role_phy))
    else $error("role changed after capture");
  a_gmii_byte:
  assert property (is_gmii && take_rise && st.s2.en |=>
                   o_ing_valid && o_ing_word.data == $past(st.s2.data))
    else $error("gmii byte lost");
  a_mii_pair:
  assert property (is_mii && take_rise && st.s2.en && st.nib_have |=>
                   o_ing_valid && o_ing_word.data[3:0] == $past(st.nib_low))
    else $error("mii nibble pairing wrong");
  a_ingress_delay:
  assert property (is_rgmii && st.cfg[BIT_INGRESS_DLY] && ing_rise |=> take_rise)
    else $error("ingress delay not applied");
  a_egress_delay:
  // A write in the same cycle may leave RGMII and gate the clock pin off
  assert property (is_rgmii && st.cfg[BIT_EGRESS_DLY] && !i_reg_write |=>
                   o_uplink_gig_rx_clock_pin == $past(st.own_clk))
    else $error("egress delay not applied");
  a_rgmii_ctl:
  assert property (s_rgmii_launch |=> o_uplink_rx_valid_pin ##0
                   o_uplink_rx_data_pins[7:4] == 4'h0)
    else $error("rgmii launch wrong");
endmodule

/* include/uplink_pkg.sv */
//------------------------------------------------------------------------------
// Purpose : Shared constants and carriers for the uplink media interface
// Assumes : 40 MHz core clock; link clocks sampled, not used as clocks
// Notes   : Register map holds the single clock-delay/mode register
//------------------------------------------------------------------------------
package uplink_pkg;

  //----------------------------------------------------------------------------
  // Register map
  //----------------------------------------------------------------------------
  localparam logic [7:0] REG_DELAY_ADDR  = 8'h56;
  localparam logic [7:0] REG_DELAY_RESET = 8'h4B;
  localparam int         BIT_MODE_LO     = 0;
  localparam int         BIT_MODE_HI     = 1;
  localparam int         BIT_ROLE_RO     = 2;
  localparam int         BIT_EGRESS_DLY  = 3;
  localparam int         BIT_INGRESS_DLY = 4;
  localparam int         BIT_HALF_DUPLEX = 5;
  localparam int         BIT_SPEED_GIG   = 6;

  //----------------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS    = 25;
  localparam int         LINK_HALF_NS     = 100;
  localparam int         LINK_HALF_CYC_I  = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] LINK_HALF_CYCLES = 3'(LINK_HALF_CYC_I);
  localparam logic [1:0] STRAP_SETTLE     = 2'h2;
  localparam int         EG_DEPTH         = 2;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MII   = 2'b00,
    MODE_RMII  = 2'b01,
    MODE_GMII  = 2'b10,
    MODE_RGMII = 2'b11
  } media_mode_t;

  typedef enum logic [1:0] {
    EG_IDLE = 2'b00,
    EG_HIGH = 2'b01
  } eg_state_t;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } link_word_t;

  typedef struct packed {
    logic       strap;
    logic       gtx;
    logic       txc;
    logic       rxc;
    logic       en;
    logic       er;
    logic       col;
    logic       crs;
    logic [7:0] data;
  } pin_sample_t;

endpackage

/* design/link_buffer.sv */
//------------------------------------------------------------------------------
// Purpose : Small valid/ready buffer in the egress data path
// Assumes : Same clock on both sides
// Notes   : Full and empty are exact; ready drops when full
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module link_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } buf_t;

  buf_t st;
  buf_t next_st;
  logic push;
  logic pop;

  assign o_in_ready  = (st.cnt != FULL);
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data  = st.mem[st.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = i_in_data;
      next_st.wp         = (st.wp == LAST) ? '0 : st.wp + PW'(1);
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST) ? '0 : st.rp + PW'(1);
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + CW'(1);
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - CW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_buf_bound:
  assert property (@(posedge i_clk) disable iff (!i_reset_n) st.cnt <= FULL)
    else $error("buffer count above depth");
endmodule

/* verif/uplink_partner.sv */
// Purpose: Far-side MAC/PHY model driving the inbound media pins
// Assumes: Link clock of 200 ns period, still between frames
// Notes  : Data is inverted after a frame so stale values never look valid
`timescale 1ns/1ps
module uplink_partner (
  // Link side
  output logic       o_clk,
  output logic       o_en,
  output logic       o_er,
  output logic [7:0] o_data
);
  initial begin
    o_clk  = 1'b0;
    o_en   = 1'b0;
    o_er   = 1'b0; // Unused error line tied low
    o_data = 8'h00;
  end
  task automatic beat(input logic [7:0] d);
    o_data = d;
    o_en   = 1'b1;
    #100 o_clk = 1'b1;
    #100 o_clk = 1'b0;
  endtask
  // Both clock edges carry a nibble; no launch delay here, as a twin set to 00
  task automatic send_ddr(input logic [7:0] b);
    o_data = {4'h0, b[3:0]};
    o_en   = 1'b1;
    #100 o_clk = 1'b1;
    #50 o_data = {4'h0, b[7:4]}; // High nibble for the falling edge
    #50 o_clk = 1'b0;
    #50 o_en = 1'b0;
    o_data = ~o_data;
  endtask
  task automatic send(input logic [7:0] b, input logic nib);
    if (nib) begin
      beat({4'h0, b[3:0]}); // Low nibble first
      beat({4'h0, b[7:4]});
    end else begin
      beat(b); // Whole byte per clock
    end
    o_en   = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

/* verif/uplink_port_media_interface_tb_top.sv */
// Purpose: Register, role, stream and status checks of the uplink port
// Assumes: Inputs change at the falling edge of the core clock
// Notes  : Strap is captured once per reset, so each role gets its own reset
`timescale 1ns/1ps
module uplink_port_media_interface_tb_top;
  import uplink_pkg::*;
  logic clk, rst_n, wr, strap, ev, col_in, crs_in, refused;
  logic [7:0] addr, wdata, pdata;
  link_word_t ew;
  int n_mismatch, cmp_count;
  wire [7:0] rdata, rxd;
  wire pclk, pen, per, mtxc_o, mtxc_oe, mrxc_o, mrxc_oe, col_o, col_oe;
  wire crs_o, crs_oe, rxv, rxe, grxc, iv, er, pcol, pcrs;
  link_word_t iw;
  wire mtxc = mtxc_oe ? mtxc_o : pclk;
  wire mrxc = mrxc_oe ? mrxc_o : pclk;
  wire col  = col_oe ? col_o : col_in;
  wire crs  = crs_oe ? crs_o : crs_in;
  uplink_partner i_uplink_partner (.o_clk(pclk), .o_en(pen), .o_er(per), .o_data(pdata));
  uplink_port_media_interface i_uplink_port_media_interface (
    .i_clk(clk), .i_reset_n(rst_n), .i_reg_write(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_role_select_strap(strap),
    .i_uplink_tx_enable_pin(pen), .i_uplink_tx_error_pin(per),
    .i_uplink_tx_data_pins(pdata), .i_uplink_gig_tx_clock_pin(pclk),
    .i_uplink_mii_tx_clock_pin(mtxc), .o_uplink_mii_tx_clock_pin(mtxc_o),
    .o_uplink_mii_tx_clock_pin_oe(mtxc_oe), .i_uplink_mii_rx_clock_pin(mrxc),
    .o_uplink_mii_rx_clock_pin(mrxc_o), .o_uplink_mii_rx_clock_pin_oe(mrxc_oe),
    .i_uplink_collision_pin(col), .o_uplink_collision_pin(col_o),
    .o_uplink_collision_pin_oe(col_oe), .i_uplink_carrier_pin(crs),
    .o_uplink_carrier_pin(crs_o), .o_uplink_carrier_pin_oe(crs_oe),
    .o_uplink_rx_valid_pin(rxv), .o_uplink_rx_error_pin(rxe),
    .o_uplink_rx_data_pins(rxd), .o_uplink_gig_rx_clock_pin(grxc),
    .o_ing_valid(iv), .o_ing_word(iw), .i_eg_valid(ev), .i_eg_word(ew),
    .o_eg_ready(er), .o_partner_collision(pcol), .o_partner_carrier(pcrs));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic give_up;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
    n_mismatch++;
    conclude();
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic boot(input logic s);
    strap = s;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    repeat (2) @(negedge clk);
    chk({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      ev = 1'b1;
      ew = '{err: i[0], data: 8'hC0 + 8'(i)};
      for (int k = 0; !er; k++) begin
        if (k > 50) give_up();
        @(negedge clk);
        refused = 1'b1;
      end
    end
    @(negedge clk);
    ev = 1'b0;
  endtask
  task automatic pull(input int n);
    logic p;
    p = 1'b1;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; !(grxc && !p && rxv); k++) begin
        if (k > 60) give_up();
        p = grxc;
        @(negedge clk);
      end
      p = grxc;
      chk({rxe, rxd}, {i[0], 8'hC0 + 8'(i)});
    end
  endtask
  task automatic getw(input logic [8:0] exp);
    for (int k = 0; !iv; k++) begin
      if (k > 80) give_up();
      @(negedge clk);
    end
    chk(iw, exp);
  endtask
  // Partner traffic overlapping our own transmit; checks collision seen against exp and carrier seen against 1
  task automatic act(input logic [7:0] c, input logic exp);
    logic sc;
    logic ss;
    {sc, ss} = 2'b00;
    wreg(8'h56, c);
    fork
      repeat (4) i_uplink_partner.send(8'h55, 1'b0);
      push(4);
      repeat (48) begin
        @(negedge clk);
        sc |= col_o;
        ss |= crs_o;
      end
    join
    chk({7'h0, sc, ss}, {7'h0, exp, 1'b1});
    repeat (40) @(negedge clk);
  endtask
  initial begin
    {wr, addr, wdata, ev, ew, col_in, crs_in, refused, n_mismatch, cmp_count} = '0;
    boot(1'b1);
    rreg(8'h56, 8'h4F);
    strap = 1'b0;
    rreg(8'h56, 8'h4F);
    wreg(8'h10, 8'hFF);
    rreg(8'h10, 8'h00);
    wreg(8'h56, 8'h5A);
    rreg(8'h56, 8'h5E);
    wreg(8'h56, 8'h42);
    chk({5'h0, mtxc_oe, mrxc_oe, col_oe, crs_oe}, 9'h003);
    fork
      i_uplink_partner.send(8'hA5, 1'b0);
      getw(9'h0A5);
    join
    refused = 1'b0;
    fork
      push(4);
      pull(4);
    join
    chk({8'h0, refused}, 9'h001);
    act(8'h22, 1'b1);
    act(8'h62, 1'b0);
    act(8'h20, 1'b1);
    chk({5'h0, mtxc_oe, mrxc_oe, col_oe, crs_oe}, 9'h00F);
    boot(1'b0);
    rreg(8'h56, 8'h4B);
    wreg(8'h56, 8'h5B);
    fork
      i_uplink_partner.send_ddr(8'h96);
      getw(9'h096);
      push(1);
    join
    {col_in, crs_in} = 2'b10;
    repeat (4) @(negedge clk);
    chk({7'h0, pcol, pcrs}, 9'h002);
    {col_in, crs_in} = 2'b01;
    repeat (4) @(negedge clk);
    chk({7'h0, pcol, pcrs}, 9'h001);
    crs_in = 1'b0;
    wreg(8'h56, 8'h00);
    chk({5'h0, mtxc_oe, mrxc_oe, col_oe, crs_oe}, 9'h000);
    fork
      i_uplink_partner.send(8'h3C, 1'b1);
      getw(9'h03C);
    join
    conclude();
  end
endmodule
